// >>> design/vr_fault_protection_logic.sv
// Fault supervision for the core rail and companion rail control bits
`timescale 1ns/100ps
`default_nettype none

// Operation
// - Sustained limit trips only after averaged current stays high for trigger delay.
// - Peak limit trips at once whenever cycle current exceeds its threshold.
// - Either trip asserts low overcurrent indicator and starts action-delay timer.
// - After action delay and settle, current still high switches off all transistors.
// - Sustained threshold selects a percentage of peak threshold from fixed options.
// - Overvoltage latches against 0.9V+325mV below 0.9V code, else reference+325mV.
// - Overvoltage forces every low side on and every high side off.
// - Overvoltage on either rail sends the other rail into soft shutdown.
// - Overvoltage comparator must hold 1us before the latch sets.
// - Latched overvoltage with output below 0V turns all low sides off.
// - Output back above 0V makes the overvoltage latch drive low sides again.
// - Negative guard only acts once the overvoltage latch is set.
// - Output 500mV under reference sets undervoltage latch, all transistors off.
// - Undervoltage must hold 3us; it also soft-shuts the other rail.
// - Either supply low for 3us locks out and halts all PWM drive.
// - Companion rail disabled by strap rejects all its voltage commands.
// - Companion on-time uses pseudo constant frequency at or above 1.8V target.
module vr_fault_protection_logic (
    input  wire logic                  ref_clk,
    input  wire logic                  resetn,
    input  wire logic                  enable,
    input  wire vr_fault_pkg::sense_t  sense_raw,
    input  wire logic [3:0]            pwm_high_req,
    input  wire logic [3:0]            pwm_low_req,
    input  wire logic [1:0]            sustained_pct_sel,
    input  wire logic [15:0]           trigger_delay_cyc,
    input  wire logic [15:0]           action_delay_cyc,
    input  wire logic                  command_for_companion,
    input  wire logic                  command_valid,
    output var  vr_fault_pkg::gate_t   gate_out,
    output logic                       overcurrent_indicator_n,
    output logic                       companion_soft_shutdown,
    output logic                       command_reject,
    output logic                       companion_on_time_pcf,
    output logic [1:0]                 sustained_pct_out,
    output logic [4:0]                 fault_status
);

    // Two-flop synchroniser on every analog comparator input
    vr_fault_pkg::sense_t sync1_q;
    vr_fault_pkg::sense_t sync2_q;
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= sense_raw;
            sync2_q <= sync1_q;
        end
    end

    // Enable pin passes two flops, then a rising edge detect for latch re-cycle
    logic enable_s1_q;
    logic enable_s2_q;
    logic enable_q;
    logic enable_d;
    logic enable_rise;
    assign enable_d    = enable_s2_q;
    assign enable_rise = enable_s2_q & ~enable_q;

    // Saturating filter step shared by voltage filters
    function automatic logic [11:0] filt_step(input logic cond, input logic [11:0] cnt,
                                              input int unsigned lim);
        if (!cond)
            filt_step = '0;
        else if (cnt < lim[11:0])
            filt_step = cnt + 12'h001;
        else
            filt_step = cnt;
    endfunction

    // Voltage fault state: filters and latches
    logic [11:0] ov_cnt_q;
    logic [11:0] ov_cnt_d;
    logic [11:0] uv_cnt_q;
    logic [11:0] uv_cnt_d;
    logic [11:0] lk_cnt_q;
    logic [11:0] lk_cnt_d;
    logic        ov_latch_q;
    logic        ov_latch_d;
    logic        uv_latch_q;
    logic        uv_latch_d;
    logic        lockout_q;
    logic        lockout_d;
    logic        ov_cond;
    logic        lk_cond;
    always_comb begin
        // Threshold choice follows voltage code
        ov_cond = sync2_q.code_below_0v9 ? sync2_q.over_fixed : sync2_q.over_ref;
        lk_cond = sync2_q.vcc_low | sync2_q.driver_supply_low;
        ov_cnt_d = filt_step(ov_cond, ov_cnt_q, vr_fault_pkg::OV_FILTER_CYC);
        uv_cnt_d = filt_step(sync2_q.under_ref, uv_cnt_q, vr_fault_pkg::UV_FILTER_CYC);
        lk_cnt_d = filt_step(lk_cond, lk_cnt_q, vr_fault_pkg::LOCKOUT_FILTER_CYC);
        ov_latch_d = ov_latch_q;
        uv_latch_d = uv_latch_q;
        if (enable_rise) begin
            ov_latch_d = 1'b0;
            uv_latch_d = 1'b0;
        end
        // Set beats re-cycle clear
        if (ov_cnt_q == 12'(vr_fault_pkg::OV_FILTER_CYC) && ov_cond) begin
            ov_latch_d = 1'b1;
        end
        if (uv_cnt_q == 12'(vr_fault_pkg::UV_FILTER_CYC) && sync2_q.under_ref) begin
            uv_latch_d = 1'b1;
        end
        // Lockout follows the filtered supply level
        lockout_d = (lk_cnt_q == 12'(vr_fault_pkg::LOCKOUT_FILTER_CYC)) && lk_cond;
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ov_cnt_q   <= '0;
            uv_cnt_q   <= '0;
            lk_cnt_q   <= '0;
            ov_latch_q <= 1'b0;
            uv_latch_q <= 1'b0;
            lockout_q  <= 1'b0;
            enable_s1_q <= 1'b0;
            enable_s2_q <= 1'b0;
            enable_q   <= 1'b0;
        end else begin
            ov_cnt_q   <= ov_cnt_d;
            uv_cnt_q   <= uv_cnt_d;
            lk_cnt_q   <= lk_cnt_d;
            ov_latch_q <= ov_latch_d;
            uv_latch_q <= uv_latch_d;
            lockout_q  <= lockout_d;
            enable_s1_q <= enable;
            enable_s2_q <= enable_s1_q;
            enable_q   <= enable_d;
        end
    end

    // Overcurrent sequence: trigger delay, action delay, settle, trip
    vr_fault_pkg::oc_state_t oc_state_q;
    vr_fault_pkg::oc_state_t oc_state_d;
    logic [15:0] sust_cnt_q;
    logic [15:0] sust_cnt_d;
    logic [15:0] oc_tmr_q;
    logic [15:0] oc_tmr_d;
    logic        sust_trip;
    logic        oc_any;
    always_comb begin
        // Sustained limit needs continuous excess for trigger delay
        if (!sync2_q.sustained_over)
            sust_cnt_d = '0;
        else if (sust_cnt_q < trigger_delay_cyc)
            sust_cnt_d = sust_cnt_q + 16'h0001;
        else
            sust_cnt_d = sust_cnt_q;
        sust_trip  = sync2_q.sustained_over && (sust_cnt_q >= trigger_delay_cyc);
        oc_any     = sust_trip | sync2_q.peak_over;
        oc_state_d = oc_state_q;
        oc_tmr_d   = oc_tmr_q;
        case (oc_state_q)
            vr_fault_pkg::OC_IDLE: begin
                if (oc_any) begin
                    oc_state_d = vr_fault_pkg::OC_ACTION;
                    oc_tmr_d   = '0;
                end
            end
            vr_fault_pkg::OC_ACTION: begin
                if (oc_tmr_q >= action_delay_cyc) begin
                    oc_state_d = vr_fault_pkg::OC_SETTLE;
                    oc_tmr_d   = '0;
                end else begin
                    oc_tmr_d = oc_tmr_q + 16'h0001;
                end
            end
            vr_fault_pkg::OC_SETTLE: begin
                if (oc_tmr_q >= vr_fault_pkg::SETTLE_DELAY_RST) begin
                    // Still above threshold trips, else the event is dropped
                    oc_state_d = (sync2_q.sustained_over | sync2_q.peak_over) ?
                                 vr_fault_pkg::OC_TRIP : vr_fault_pkg::OC_IDLE;
                    oc_tmr_d   = '0;
                end else begin
                    oc_tmr_d = oc_tmr_q + 16'h0001;
                end
            end
            vr_fault_pkg::OC_TRIP: begin
                if (enable_rise)
                    oc_state_d = vr_fault_pkg::OC_IDLE;
            end
            default: oc_state_d = vr_fault_pkg::OC_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            oc_state_q <= vr_fault_pkg::OC_IDLE;
            sust_cnt_q <= '0;
            oc_tmr_q   <= '0;
        end else begin
            oc_state_q <= oc_state_d;
            sust_cnt_q <= sust_cnt_d;
            oc_tmr_q   <= oc_tmr_d;
        end
    end

    // Companion rail faults soft-shut this rail below the local latches
    logic other_fault;
    assign other_fault = sync2_q.companion_ov | sync2_q.companion_uv;

    // Registered outputs: gate forcing, indicator and companion control
    vr_fault_pkg::gate_t gate_d;
    logic       oc_ind_n_d;
    logic       soft_sd_d;
    logic       reject_d;
    logic       pcf_d;
    logic [4:0] status_d;
    always_comb begin
        gate_d.high_on = pwm_high_req;
        gate_d.low_on  = pwm_low_req;
        if (lockout_q || uv_latch_q || oc_state_q == vr_fault_pkg::OC_TRIP) begin
            gate_d = '0;
        end else if (ov_latch_q) begin
            gate_d.high_on = 4'h0;
            // Negative guard only under latched overvoltage
            gate_d.low_on  = sync2_q.below_zero ? 4'h0 : 4'hF;
        end else if (other_fault) begin
            gate_d = '0;
        end
        oc_ind_n_d = (oc_state_q == vr_fault_pkg::OC_IDLE) && !oc_any;
        soft_sd_d  = ov_latch_q | uv_latch_q;
        reject_d   = command_valid && command_for_companion
                     && sync2_q.companion_phase1_sense_neg_hi;
        pcf_d      = sync2_q.companion_dac_hi;
        status_d   = {lockout_q, uv_latch_q, ov_latch_q,
                      ov_latch_q & sync2_q.below_zero, oc_state_q == vr_fault_pkg::OC_TRIP};
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            gate_out                <= '0;
            overcurrent_indicator_n <= 1'b1;
            companion_soft_shutdown <= 1'b0;
            command_reject          <= 1'b0;
            companion_on_time_pcf   <= 1'b0;
            sustained_pct_out       <= vr_fault_pkg::SUST_PCT_OPT0;
            fault_status            <= '0;
        end else begin
            gate_out                <= gate_d;
            overcurrent_indicator_n <= oc_ind_n_d;
            companion_soft_shutdown <= soft_sd_d;
            command_reject          <= reject_d;
            companion_on_time_pcf   <= pcf_d;
            sustained_pct_out       <= sustained_pct_sel;
            fault_status            <= status_d;
        end
    end

endmodule
`default_nettype wire

// >>> include/vr_fault_pkg.sv
// Package with timing constants, option encodings and carrier types for fault supervision
package vr_fault_pkg;

    // Clock rate in kHz (125 MHz)
    localparam int unsigned CLK_KHZ            = 125000;

    // Filter times in nanoseconds
    localparam int unsigned OV_FILTER_NS       = 1000;
    localparam int unsigned UV_FILTER_NS       = 3000;
    localparam int unsigned LOCKOUT_FILTER_NS  = 3000;

    // Least times round up to whole cycles
    localparam int unsigned OV_FILTER_CYC      = (OV_FILTER_NS * (CLK_KHZ / 1000) + 999) / 1000;
    localparam int unsigned UV_FILTER_CYC      = (UV_FILTER_NS * (CLK_KHZ / 1000) + 999) / 1000;
    localparam int unsigned LOCKOUT_FILTER_CYC =
        (LOCKOUT_FILTER_NS * (CLK_KHZ / 1000) + 999) / 1000;

    // Filter counter width
    localparam int unsigned FILT_W             = 12;

    // Overcurrent timer width and defaults (cycles)
    localparam int unsigned OC_TIMER_W         = 16;
    localparam logic [15:0] TRIGGER_DELAY_RST  = 16'h0100;
    localparam logic [15:0] ACTION_DELAY_RST   = 16'h0200;
    localparam logic [15:0] SETTLE_DELAY_RST   = 16'h0040;

    // Sustained-limit option encodings (percent of peak threshold)
    localparam logic [1:0] SUST_PCT_OPT0       = 2'h0;
    localparam logic [1:0] SUST_PCT_OPT1       = 2'h1;
    localparam logic [1:0] SUST_PCT_OPT2       = 2'h2;
    localparam logic [1:0] SUST_PCT_OPT3       = 2'h3;

    // Overcurrent sequence states
    typedef enum logic [1:0] {
        OC_IDLE   = 2'b00,
        OC_ACTION = 2'b01,
        OC_SETTLE = 2'b10,
        OC_TRIP   = 2'b11
    } oc_state_t;

    // Raw comparator results from the analog front end
    typedef struct packed {
        logic sustained_over;     // Averaged current above sustained threshold
        logic peak_over;          // Cycle current above peak threshold
        logic over_fixed;         // Sense above 0.9V plus 325mV
        logic over_ref;           // Sense above reference plus 325mV
        logic code_below_0v9;     // Voltage code below 0.9V
        logic below_zero;         // Sense below 0V
        logic under_ref;          // Sense 500mV below reference
        logic vcc_low;            // Controller supply below power-on level
        logic driver_supply_low;  // Driver supply pin below power-on level
        logic companion_ov;       // Overvoltage latched on companion rail
        logic companion_uv;       // Undervoltage latched on companion rail
        logic companion_dac_hi;   // Companion DAC target at or above 1.8V
        logic companion_phase1_sense_neg_hi; // Companion phase-1 neg sense above supply
    } sense_t;

    // Gate drive enables for every phase
    typedef struct packed {
        logic [3:0] high_on;
        logic [3:0] low_on;
    } gate_t;

endpackage

// >>> verif/vr_fault_properties.sv
// Concurrent checks on the fault supervision ports
`timescale 1ns/100ps
`default_nettype none
module vr_fault_properties (
    input wire logic                 ref_clk,
    input wire logic                 resetn,
    input wire logic                 enable,
    input wire vr_fault_pkg::sense_t sense_raw,
    input wire logic [3:0]           pwm_high_req,
    input wire logic [3:0]           pwm_low_req,
    input wire logic [1:0]           sustained_pct_sel,
    input wire logic [15:0]          trigger_delay_cyc,
    input wire logic [15:0]          action_delay_cyc,
    input wire logic                 command_for_companion,
    input wire logic                 command_valid,
    input wire vr_fault_pkg::gate_t  gate_out,
    input wire logic                 overcurrent_indicator_n,
    input wire logic                 companion_soft_shutdown,
    input wire logic                 command_reject,
    input wire logic                 companion_on_time_pcf,
    input wire logic [1:0]           sustained_pct_out,
    input wire logic [4:0]           fault_status
);
    localparam logic [11:0] OV_MIN = 12'(vr_fault_pkg::OV_FILTER_CYC);
    localparam logic [11:0] UV_MIN = 12'(vr_fault_pkg::UV_FILTER_CYC);
    logic [11:0] ov_run_q, ov_run_d, uv_run_q, uv_run_d;
    logic        ov_cond;
    // Consecutive high-cycle counts of the raw voltage comparators
    always_comb begin
        ov_cond = sense_raw.code_below_0v9 ? sense_raw.over_fixed : sense_raw.over_ref;
        ov_run_d = !ov_cond ? 12'h000 : (&ov_run_q) ? ov_run_q : ov_run_q + 12'h001;
        uv_run_d = !sense_raw.under_ref ? 12'h000 : (&uv_run_q) ? uv_run_q : uv_run_q + 12'h001;
    end
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ov_run_q <= 12'h000;
            uv_run_q <= 12'h000;
        end else begin
            ov_run_q <= ov_run_d;
            uv_run_q <= uv_run_d;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    // Status and gates register on the same edge, so both are compared in one cycle
    chk_ov_filter_time: assert property ($rose(fault_status[2]) |-> ov_run_q >= OV_MIN)
        else $error("overvoltage latched before its filter time");
    chk_uv_filter_time: assert property ($rose(fault_status[3]) |-> uv_run_q >= UV_MIN)
        else $error("undervoltage latched before its filter time");
    chk_ov_high_off: assert property (fault_status[2] |-> gate_out.high_on == 4'h0)
        else $error("high side on during overvoltage");
    chk_uv_all_off: assert property (fault_status[3] |-> gate_out == 8'h00)
        else $error("gates on during undervoltage");
    chk_lockout_all_off: assert property (fault_status[4] |-> gate_out == 8'h00)
        else $error("gates on during lockout");
    chk_trip_all_off: assert property (fault_status[0] |-> gate_out == 8'h00)
        else $error("gates on after overcurrent trip");
    chk_trip_ind_low: assert property (fault_status[0] |-> !overcurrent_indicator_n)
        else $error("indicator high while tripped");
    chk_neg_needs_ov: assert property (fault_status[1] |-> fault_status[2])
        else $error("negative guard without overvoltage");
    chk_neg_low_off: assert property (fault_status[1] |-> gate_out.low_on == 4'h0)
        else $error("low side on during negative guard");
    chk_ov_soft_shut: assert property (
        $rose(fault_status[2]) |-> ##[0:1] companion_soft_shutdown)
        else $error("no soft shutdown on overvoltage");
    chk_pcf_mode_high: assert property (
        ($past(resetn) && sense_raw.companion_dac_hi)[*4] |-> companion_on_time_pcf)
        else $error("pseudo constant frequency not selected");
    chk_pcf_mode_low: assert property (
        ($past(resetn) && !sense_raw.companion_dac_hi)[*4] |-> !companion_on_time_pcf)
        else $error("pseudo constant frequency wrongly selected");
    chk_pct_echo: assert property (
        ($past(resetn) && $stable(sustained_pct_sel))[*4] |-> sustained_pct_out == sustained_pct_sel)
        else $error("sustained option not echoed");
    cover property ($rose(fault_status[2]));
    cover property ($rose(fault_status[1]));
    cover property ($rose(fault_status[0]));
endmodule
`default_nettype wire

// >>> verif/gate_driver_model.sv
// Gate driver stand-in that flags shoot-through on any phase
`timescale 1ns/100ps
`default_nettype none
module gate_driver_model (
    input wire logic                ref_clk,
    input wire logic                resetn,
    input wire vr_fault_pkg::gate_t gate_out,
    output logic [3:0]              shoot_thru
);
    // Sticky record of both switches of a phase on together
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) shoot_thru <= 4'h0;
        else shoot_thru <= shoot_thru | (gate_out.high_on & gate_out.low_on);
    end
endmodule
`default_nettype wire

// >>> verif/vr_fault_protection_logic_tb_top.sv
// Self-checking bench for the fault supervision block
`timescale 1ns/100ps
`default_nettype none
module vr_fault_protection_logic_tb_top;
    logic ref_clk, resetn, enable, command_for_companion, command_valid;
    logic overcurrent_indicator_n, companion_soft_shutdown, command_reject, companion_on_time_pcf;
    logic [3:0] pwm_high_req, pwm_low_req, shoot_thru, h;
    logic [1:0] sustained_pct_sel, sustained_pct_out;
    logic [15:0] trigger_delay_cyc, action_delay_cyc;
    logic [4:0] fault_status;
    logic [7:0] q_exp[$], e_cur;
    vr_fault_pkg::sense_t sense_raw;
    vr_fault_pkg::gate_t gate_out;
    int err_total, n_tests, rej_cnt, s_cur, i, k;
    int q_sel[$];
    string nm[8] = '{"gate", "status", "ind_n", "soft", "rejects", "pcf", "pct", "shoot"};
    vr_fault_protection_logic uut (.ref_clk, .resetn, .enable, .sense_raw, .pwm_high_req,
        .pwm_low_req, .sustained_pct_sel, .trigger_delay_cyc, .action_delay_cyc,
        .command_for_companion, .command_valid, .gate_out, .overcurrent_indicator_n,
        .companion_soft_shutdown, .command_reject, .companion_on_time_pcf,
        .sustained_pct_out, .fault_status);
    gate_driver_model u_drv (.ref_clk, .resetn, .gate_out, .shoot_thru);
    function automatic logic [7:0] obs(input int s);
        case (s)
            0: return gate_out;
            1: return {3'h0, fault_status};
            2: return {7'h0, overcurrent_indicator_n};
            3: return {7'h0, companion_soft_shutdown};
            4: return rej_cnt[7:0];
            5: return {7'h0, companion_on_time_pcf};
            6: return {6'h0, sustained_pct_out};
            default: return {4'h0, shoot_thru};
        endcase
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic note(input int s, input logic [7:0] e);
        q_sel.push_back(s);
        q_exp.push_back(e);
    endtask
    task automatic recycle();
        enable <= 1'b0;
        cyc(3);
        enable <= 1'b1;
        cyc(8);
    endtask
    task automatic cmd(input logic comp);
        command_for_companion <= comp;
        command_valid <= 1'b1;
        cyc(1);
        command_valid <= 1'b0;
        cyc(8);
    endtask
    task automatic setov(input logic fixed, input logic v);
        if (fixed) sense_raw.over_fixed <= v;
        else sense_raw.over_ref <= v;
    endtask
    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Clock and watchdog
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        err_total++;
        end_sim();
    end
    // Reject pulse counter and queued output comparisons
    always @(posedge ref_clk) if (command_reject === 1'b1) rej_cnt <= rej_cnt + 1;
    always @(negedge ref_clk) while (q_sel.size() > 0) begin
        s_cur = q_sel.pop_front();
        e_cur = q_exp.pop_front();
        n_tests++;
        if (obs(s_cur) !== e_cur) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm[s_cur], e_cur, obs(s_cur));
        end
    end
    // Stimulus
    initial begin
        void'($urandom(53));
        {resetn, enable, command_for_companion, command_valid, rej_cnt} = '0;
        {sense_raw, pwm_high_req, pwm_low_req, sustained_pct_sel} = '0;
        trigger_delay_cyc = 16'h0040;
        action_delay_cyc = 16'h0010;
        cyc(10);
        resetn <= 1'b1;
        cyc(1);
        note(0, 8'h00);
        note(1, 8'h00);
        note(2, 8'h01);
        note(3, 8'h00);
        note(5, 8'h00);
        enable <= 1'b1;
        for (i = 0; i < 4; i++) begin
            h = 4'($urandom);
            pwm_high_req <= h;
            pwm_low_req <= ~h;
            cyc(4);
            note(0, {h, ~h});
            sustained_pct_sel <= 2'(i);
            cyc(5);
            note(6, 8'(i));
        end
        sense_raw.companion_dac_hi <= 1'b1;
        cyc(6);
        note(5, 8'h01);
        sense_raw.companion_dac_hi <= 1'b0;
        cyc(6);
        note(5, 8'h00);
        sense_raw.companion_phase1_sense_neg_hi <= 1'b1;
        cyc(5);
        cmd(1'b1);
        note(4, 8'h01);
        cmd(1'b0);
        sense_raw.companion_phase1_sense_neg_hi <= 1'b0;
        cyc(5);
        cmd(1'b1);
        note(4, 8'h01);
        sense_raw.below_zero <= 1'b1;
        cyc(10);
        note(1, 8'h00);
        sense_raw.below_zero <= 1'b0;
        pwm_high_req <= 4'hF;
        pwm_low_req <= 4'h0;
        for (k = 0; k < 2; k++) begin
            sense_raw.code_below_0v9 <= (k == 0);
            setov(k != 0, 1'b1);
            cyc(200);
            note(1, 8'h00);
            setov(k != 0, 1'b0);
            setov(k == 0, 1'b1);
            cyc(20 + $urandom_range(80));
            setov(k == 0, 1'b0);
            cyc(10);
            note(1, 8'h00);
            setov(k == 0, 1'b1);
            cyc(140);
            note(1, 8'h04);
            note(0, 8'h0F);
            note(3, 8'h01);
            sense_raw.below_zero <= 1'b1;
            cyc(6);
            note(1, 8'h06);
            note(0, 8'h00);
            sense_raw.below_zero <= 1'b0;
            cyc(6);
            note(0, 8'h0F);
            // A companion fault must not undo the local overvoltage clamp
            sense_raw.companion_uv <= 1'b1;
            cyc(6);
            note(0, 8'h0F);
            sense_raw.companion_uv <= 1'b0;
            setov(k == 0, 1'b0);
            cyc(20);
            note(1, 8'h04);
            recycle();
            note(1, 8'h00);
            note(0, 8'hF0);
        end
        sense_raw.under_ref <= 1'b1;
        cyc(300);
        note(1, 8'h00);
        cyc(100);
        note(1, 8'h08);
        note(0, 8'h00);
        note(3, 8'h01);
        sense_raw.under_ref <= 1'b0;
        recycle();
        for (k = 0; k < 2; k++) begin
            if (k == 0) sense_raw.vcc_low <= 1'b1;
            else sense_raw.driver_supply_low <= 1'b1;
            cyc(300);
            note(1, 8'h00);
            cyc(100);
            note(1, 8'h10);
            note(0, 8'h00);
            sense_raw.vcc_low <= 1'b0;
            sense_raw.driver_supply_low <= 1'b0;
            cyc(10);
            note(1, 8'h00);
            note(0, 8'hF0);
        end
        // Companion rail faults soft-shut this rail's gates
        sense_raw.companion_ov <= 1'b1;
        cyc(6);
        note(0, 8'h00);
        sense_raw.companion_ov <= 1'b0;
        sense_raw.companion_uv <= 1'b1;
        cyc(6);
        note(0, 8'h00);
        sense_raw.companion_uv <= 1'b0;
        cyc(6);
        note(0, 8'hF0);
        sense_raw.sustained_over <= 1'b1;
        cyc(40);
        sense_raw.sustained_over <= 1'b0;
        cyc(4);
        note(2, 8'h01);
        sense_raw.sustained_over <= 1'b1;
        cyc(75);
        note(2, 8'h00);
        cyc(100);
        note(1, 8'h01);
        note(0, 8'h00);
        sense_raw.sustained_over <= 1'b0;
        recycle();
        note(2, 8'h01);
        sense_raw.peak_over <= 1'b1;
        cyc(1);
        sense_raw.peak_over <= 1'b0;
        cyc(4);
        note(2, 8'h00);
        cyc(120);
        note(1, 8'h00);
        sense_raw.peak_over <= 1'b1;
        cyc(130);
        note(1, 8'h01);
        note(0, 8'h00);
        note(7, 8'h00);
        cyc(2);
        end_sim();
    end
endmodule
bind vr_fault_protection_logic vr_fault_properties u_props (.ref_clk, .resetn, .enable,
    .sense_raw, .pwm_high_req, .pwm_low_req, .sustained_pct_sel, .trigger_delay_cyc,
    .action_delay_cyc, .command_for_companion, .command_valid, .gate_out,
    .overcurrent_indicator_n, .companion_soft_shutdown, .command_reject,
    .companion_on_time_pcf, .sustained_pct_out, .fault_status);
`default_nettype wire
